// ==== adcc_regs.vh ====
// Register map, field positions and timing constants of the converter control block.
// Assumes a 20 MHz system clock and Avalon-MM byte addressing with 32-bit words.
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ADCC_OFF_CTL0      5'h00
`define ADCC_OFF_STATUS    5'h04
`define ADCC_OFF_IRQ_STAT  5'h08
`define ADCC_OFF_IRQ_EN    5'h0c
`define ADCC_OFF_IRQ_CLR   5'h10
`define ADCC_OFF_AUX       5'h14

// ---------------------------------------------------------------
// Control register 0 fields
// ---------------------------------------------------------------
`define ADCC_CTL0_EN       15
`define ADCC_CTL0_SR       14
`define ADCC_CTL0_FRZ      13
`define ADCC_CTL0_WAI      12
`define ADCC_CTL0_ACC_HI   11
`define ADCC_CTL0_ACC_LO   10
`define ADCC_CTL0_STR      9
`define ADCC_CTL0_MOD      8
`define ADCC_ACC_RESET     2'h0

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define ADCC_ST_POWERED    0
`define ADCC_ST_DRAINING   1
`define ADCC_ST_READY      2
`define ADCC_ST_HALTED     3
`define ADCC_ST_CSL        4
`define ADCC_ST_RVL        5
`define ADCC_ST_SR_BUSY    6
`define ADCC_ST_CIDX_LO    8
`define ADCC_ST_RIDX_LO    16

// ---------------------------------------------------------------
// Interrupt status / enable / clear fields
// ---------------------------------------------------------------
`define ADCC_IRQ_W         5
`define ADCC_IRQ_OVERRUN   0
`define ADCC_IRQ_SEVERE    1
`define ADCC_IRQ_EARLY     2
`define ADCC_IRQ_SR_DONE   3
`define ADCC_IRQ_READY     4

// ---------------------------------------------------------------
// Auxiliary register fields
// ---------------------------------------------------------------
`define ADCC_AUX_SMOD      0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ADCC_CLK_NS        50
`define ADCC_T_REC_NS      1000
`define ADCC_REC_CYC       ((`ADCC_T_REC_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_SR_CYC        16'h0002

`endif

// ==== adcc_ctl0.v ====
// Converter control register 0 with enable, soft reset, halt options and flow config locks.
// Assumes an Avalon-MM master on clk and a converter core on the same clock.
//
// How it works
// - Enable, soft reset, freeze select and wait select are writable regardless of the configuration lock.
// - Flow mode, abort store and access path fields change only when disabled or in special-mode access.
// - Bit 15 powers the converter internals and locks the flow configuration fields.
// - Clearing enable aborts the running sequence and drops the current and pending results.
// - Enable cannot be set again until the aborted work has drained.
// - A recovery period follows enabling; triggers before it ends are refused and flagged.
// - Soft reset clears overrun and error flags and forces the sequencer to idle.
// - Soft reset also clears both indices and both list selects.
// - A severe error stops operation until software issues a soft reset.
// - The soft reset bit ignores writes while set and is cleared by hardware when done.
// - With freeze select set, conversion stops at the next boundary in freeze mode.
// - With wait select set, conversion halts at the next boundary in wait mode.
// - Flow mode zero restarts after end of list, one waits for a trigger.
// - The access path field encodes none, internal, bus or both, and resets to none.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.vh"

module adcc_ctl0 #(
    parameter IDX_W   = 6,
    parameter REC_CYC = `ADCC_REC_CYC
) (
    input  wire              clk,
    input  wire              reset_n,
    input  wire [4:0]        address,
    input  wire              read,
    input  wire              write,
    input  wire [31:0]       writedata,
    input  wire [3:0]        byteenable,
    output reg  [31:0]       readdata,
    output wire              waitrequest,
    output wire              irq,
    input  wire              mcu_special_mode,
    input  wire              freeze_mode,
    input  wire              wait_mode,
    input  wire              trigger_req,
    input  wire              conv_busy,
    input  wire              conv_boundary,
    input  wire              conv_done,
    input  wire              end_of_list,
    input  wire              overrun_event,
    input  wire              severe_error_event,
    output reg               analog_power_en,
    output reg               conv_abort,
    output wire              conv_launch,
    output wire              result_store,
    output wire              seq_restart,
    output reg               sm_idle_force,
    output reg               conv_halt,
    output reg  [IDX_W-1:0]  command_index,
    output reg  [IDX_W-1:0]  result_index,
    output reg               active_command_list_select,
    output reg               active_result_list_select,
    output reg               flow_mode_select,
    output reg               abort_store_select,
    output reg  [1:0]        flow_reg_access_path
);

// ---------------------------------------------------------------
// States
// ---------------------------------------------------------------
localparam ST_OFF   = 3'h0;
localparam ST_DRAIN = 3'h1;
localparam ST_RECOV = 3'h2;
localparam ST_RUN   = 3'h3;
localparam ST_SRST  = 3'h4;

localparam [`ADCC_IRQ_W-1:0] IRQ_SR_CLR = ({{(`ADCC_IRQ_W-1){1'b0}}, 1'b1} << `ADCC_IRQ_OVERRUN)
                                        | ({{(`ADCC_IRQ_W-1){1'b0}}, 1'b1} << `ADCC_IRQ_SEVERE)
                                        | ({{(`ADCC_IRQ_W-1){1'b0}}, 1'b1} << `ADCC_IRQ_EARLY);

// ---------------------------------------------------------------
// Reset release
// ---------------------------------------------------------------
reg  rst_meta_reg;
reg  rst_n_reg;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        rst_meta_reg <= 1'b0;
        rst_n_reg    <= 1'b0;
    end
    else
    begin
        rst_meta_reg <= 1'b1;
        rst_n_reg    <= rst_meta_reg;
    end
end

// ---------------------------------------------------------------
// Bus slave
// ---------------------------------------------------------------
reg                       ack_reg;
reg                       enable_reg;
reg                       soft_reset_request;
reg                       freeze_halt_select;
reg                       wait_halt_select;
reg                       special_mode_access;
reg  [2:0]                state_reg;
reg  [15:0]               timer_reg;
reg                       severe_reg;
reg  [`ADCC_IRQ_W-1:0]    irq_stat_reg;
reg  [`ADCC_IRQ_W-1:0]    irq_en_reg;
reg  [`ADCC_IRQ_W-1:0]    irq_set;
reg  [31:0]               rd_next;

wire wr_go  = write && ack_reg;
wire wr_hi  = wr_go && byteenable[1];
wire wr_lo  = wr_go && byteenable[0];
wire ctl_wr = wr_hi && (address == `ADCC_OFF_CTL0);
wire cfg_ok = !enable_reg || special_mode_access;

assign waitrequest = (read || write) && !ack_reg;

function [31:0] adcc_ctl0_word;
    input en;
    input sr;
    input frz;
    input wai;
    input [1:0] acc;
    input str;
    input md;
    begin
        adcc_ctl0_word = 32'h0000_0000;
        adcc_ctl0_word[`ADCC_CTL0_EN] = en;
        adcc_ctl0_word[`ADCC_CTL0_SR] = sr;
        adcc_ctl0_word[`ADCC_CTL0_FRZ] = frz;
        adcc_ctl0_word[`ADCC_CTL0_WAI] = wai;
        adcc_ctl0_word[`ADCC_CTL0_ACC_HI:`ADCC_CTL0_ACC_LO] = acc;
        adcc_ctl0_word[`ADCC_CTL0_STR] = str;
        adcc_ctl0_word[`ADCC_CTL0_MOD] = md;
    end
endfunction

always @*
begin
    rd_next = 32'h0000_0000;
    case (address)
        `ADCC_OFF_CTL0:
            rd_next = adcc_ctl0_word(enable_reg, soft_reset_request, freeze_halt_select,
                                     wait_halt_select, flow_reg_access_path,
                                     abort_store_select, flow_mode_select);
        `ADCC_OFF_STATUS:
        begin
            rd_next[`ADCC_ST_POWERED]  = analog_power_en;
            rd_next[`ADCC_ST_DRAINING] = (state_reg == ST_DRAIN);
            rd_next[`ADCC_ST_READY]    = (state_reg == ST_RUN);
            rd_next[`ADCC_ST_HALTED]   = conv_halt || severe_reg;
            rd_next[`ADCC_ST_CSL]      = active_command_list_select;
            rd_next[`ADCC_ST_RVL]      = active_result_list_select;
            rd_next[`ADCC_ST_SR_BUSY]  = soft_reset_request;
            rd_next[`ADCC_ST_CIDX_LO +: IDX_W] = command_index;
            rd_next[`ADCC_ST_RIDX_LO +: IDX_W] = result_index;
        end
        `ADCC_OFF_IRQ_STAT:
            rd_next[`ADCC_IRQ_W-1:0] = irq_stat_reg;
        `ADCC_OFF_IRQ_EN:
            rd_next[`ADCC_IRQ_W-1:0] = irq_en_reg;
        `ADCC_OFF_AUX:
            rd_next[`ADCC_AUX_SMOD] = special_mode_access;
        default:
            rd_next = 32'h0000_0000;
    endcase
end

always @(posedge clk or negedge rst_n_reg)
begin
    if (!rst_n_reg)
    begin
        ack_reg  <= 1'b0;
        readdata <= 32'h0000_0000;
    end
    else
    begin
        ack_reg <= (read || write) && !ack_reg;
        if (read && !ack_reg)
            readdata <= rd_next;
    end
end

// ---------------------------------------------------------------
// Control register 0 and auxiliary register
// ---------------------------------------------------------------
wire sr_done = (state_reg == ST_SRST) && (timer_reg == 16'h0000);

always @(posedge clk or negedge rst_n_reg)
begin
    if (!rst_n_reg)
    begin
        enable_reg           <= 1'b0;
        soft_reset_request   <= 1'b0;
        freeze_halt_select   <= 1'b0;
        wait_halt_select     <= 1'b0;
        flow_reg_access_path <= `ADCC_ACC_RESET;
        abort_store_select   <= 1'b0;
        flow_mode_select     <= 1'b0;
        special_mode_access  <= 1'b0;
    end
    else
    begin
        if (ctl_wr)
        begin
            if (writedata[`ADCC_CTL0_EN] && (state_reg == ST_DRAIN || conv_busy && !enable_reg))
                enable_reg <= 1'b0;
            else
                enable_reg <= writedata[`ADCC_CTL0_EN];
            freeze_halt_select <= writedata[`ADCC_CTL0_FRZ];
            wait_halt_select   <= writedata[`ADCC_CTL0_WAI];
            if (cfg_ok)
            begin
                flow_reg_access_path <= writedata[`ADCC_CTL0_ACC_HI:`ADCC_CTL0_ACC_LO];
                abort_store_select   <= writedata[`ADCC_CTL0_STR];
                flow_mode_select     <= writedata[`ADCC_CTL0_MOD];
            end
        end
        if (sr_done)
            soft_reset_request <= 1'b0;
        else if (ctl_wr && writedata[`ADCC_CTL0_SR])
            soft_reset_request <= 1'b1;
        if (wr_lo && address == `ADCC_OFF_AUX && mcu_special_mode)
            special_mode_access <= writedata[`ADCC_AUX_SMOD];
    end
end

// ---------------------------------------------------------------
// Sequencer
// ---------------------------------------------------------------
wire running   = (state_reg == ST_RUN) && !severe_reg;
wire early_trg = trigger_req && (state_reg == ST_RECOV);
wire halt_req  = (freeze_mode && freeze_halt_select) || (wait_mode && wait_halt_select);

assign conv_launch  = trigger_req && running && !conv_halt;
assign result_store = conv_done && running;
assign seq_restart  = end_of_list && running && !flow_mode_select && !conv_halt;

always @(posedge clk or negedge rst_n_reg)
begin
    if (!rst_n_reg)
    begin
        state_reg       <= ST_OFF;
        timer_reg       <= 16'h0000;
        analog_power_en <= 1'b0;
        conv_abort      <= 1'b0;
        sm_idle_force   <= 1'b0;
        conv_halt       <= 1'b0;
    end
    else
    begin
        conv_abort    <= 1'b0;
        sm_idle_force <= 1'b0;
        if (!halt_req)
            conv_halt <= 1'b0;
        else if (conv_boundary || !conv_busy)
            conv_halt <= 1'b1;
        case (state_reg)
            ST_OFF:
            begin
                analog_power_en <= 1'b0;
                if (soft_reset_request)
                begin
                    state_reg <= ST_SRST;
                    timer_reg <= `ADCC_SR_CYC;
                end
                else if (enable_reg)
                begin
                    analog_power_en <= 1'b1;
                    state_reg       <= ST_RECOV;
                    timer_reg       <= REC_CYC[15:0];
                end
            end
            ST_DRAIN:
                if (!conv_busy)
                    state_reg <= ST_OFF;
            ST_RECOV, ST_RUN:
            begin
                if (soft_reset_request)
                begin
                    state_reg <= ST_SRST;
                    timer_reg <= `ADCC_SR_CYC;
                end
                else if (!enable_reg)
                begin
                    analog_power_en <= 1'b0;
                    conv_abort      <= 1'b1;
                    state_reg       <= ST_DRAIN;
                end
                else if (state_reg == ST_RECOV)
                begin
                    if (timer_reg == 16'h0000)
                        state_reg <= ST_RUN;
                    else
                        timer_reg <= timer_reg - 16'h0001;
                end
            end
            ST_SRST:
            begin
                sm_idle_force <= 1'b1;
                if (timer_reg != 16'h0000)
                    timer_reg <= timer_reg - 16'h0001;
                else if (enable_reg && analog_power_en)
                    state_reg <= ST_RUN;
                else
                begin
                    conv_abort      <= analog_power_en;
                    analog_power_en <= 1'b0;
                    state_reg       <= ST_OFF;
                end
            end
            default:
                state_reg <= ST_OFF;
        endcase
    end
end

// ---------------------------------------------------------------
// Indices, list selects and severe error
// ---------------------------------------------------------------
always @(posedge clk or negedge rst_n_reg)
begin
    if (!rst_n_reg)
    begin
        command_index              <= {IDX_W{1'b0}};
        result_index               <= {IDX_W{1'b0}};
        active_command_list_select <= 1'b0;
        active_result_list_select  <= 1'b0;
        severe_reg                 <= 1'b0;
    end
    else if (state_reg == ST_SRST)
    begin
        command_index              <= {IDX_W{1'b0}};
        result_index               <= {IDX_W{1'b0}};
        active_command_list_select <= 1'b0;
        active_result_list_select  <= 1'b0;
        severe_reg                 <= severe_error_event;
    end
    else
    begin
        if (severe_error_event)
            severe_reg <= 1'b1;
        if (running && end_of_list)
        begin
            command_index              <= {IDX_W{1'b0}};
            result_index               <= {IDX_W{1'b0}};
            active_command_list_select <= !active_command_list_select;
            active_result_list_select  <= !active_result_list_select;
        end
        else
        begin
            if (conv_launch)
                command_index <= command_index + {{(IDX_W-1){1'b0}}, 1'b1};
            if (result_store)
                result_index <= result_index + {{(IDX_W-1){1'b0}}, 1'b1};
        end
    end
end

// ---------------------------------------------------------------
// Interrupts
// ---------------------------------------------------------------
wire irq_clr_wr = wr_lo && (address == `ADCC_OFF_IRQ_CLR);

always @*
begin
    irq_set = {`ADCC_IRQ_W{1'b0}};
    irq_set[`ADCC_IRQ_OVERRUN] = overrun_event;
    irq_set[`ADCC_IRQ_SEVERE]  = severe_error_event;
    irq_set[`ADCC_IRQ_EARLY]   = early_trg;
    irq_set[`ADCC_IRQ_SR_DONE] = sr_done;
    irq_set[`ADCC_IRQ_READY]   = (state_reg == ST_RECOV) && enable_reg && !soft_reset_request
                                 && (timer_reg == 16'h0000);
end

always @(posedge clk or negedge rst_n_reg)
begin
    if (!rst_n_reg)
    begin
        irq_stat_reg <= {`ADCC_IRQ_W{1'b0}};
        irq_en_reg   <= {`ADCC_IRQ_W{1'b0}};
    end
    else
    begin
        if (state_reg == ST_SRST)
            irq_stat_reg <= (irq_stat_reg & ~IRQ_SR_CLR) | irq_set;
        else if (irq_clr_wr)
            irq_stat_reg <= (irq_stat_reg & ~writedata[`ADCC_IRQ_W-1:0]) | irq_set;
        else
            irq_stat_reg <= irq_stat_reg | irq_set;
        if (wr_lo && address == `ADCC_OFF_IRQ_EN)
            irq_en_reg <= writedata[`ADCC_IRQ_W-1:0];
    end
end

assign irq = |(irq_stat_reg & irq_en_reg);

endmodule // adcc_ctl0
`default_nettype wire

// ==== adcc_ctl0_monitor.sv ====
// Assertions on the ports of the converter control block.
// Assumes it is bound onto adcc_ctl0, which has one clock domain.
`timescale 1ns/1ns
`default_nettype none
module adcc_monitor #(
    parameter IDX_W = 6
) (
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic             read,
    input wire logic             write,
    input wire logic             waitrequest,
    input wire logic             trigger_req,
    input wire logic             conv_done,
    input wire logic             end_of_list,
    input wire logic             freeze_mode,
    input wire logic             wait_mode,
    input wire logic             analog_power_en,
    input wire logic             conv_abort,
    input wire logic             conv_launch,
    input wire logic             result_store,
    input wire logic             seq_restart,
    input wire logic             sm_idle_force,
    input wire logic             conv_halt,
    input wire logic [IDX_W-1:0] command_index,
    input wire logic [IDX_W-1:0] result_index,
    input wire logic             active_command_list_select,
    input wire logic             active_result_list_select,
    input wire logic             flow_mode_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ------
    // Sequences
    // ------
    sequence no_halt_req;
        !freeze_mode && !wait_mode;
    endsequence
    sequence idle_cleared;
        command_index == 0 && result_index == 0 && !active_command_list_select && !active_result_list_select;
    endsequence

    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    abort_pulse_a: assert property (conv_abort |=> !conv_abort)
        else $error("abort pulse too long");
    abort_power_a: assert property ($fell(analog_power_en) |-> conv_abort || $past(conv_abort))
        else $error("power off without abort");
    launch_gate_a: assert property (conv_launch |-> trigger_req && analog_power_en && !conv_halt)
        else $error("launch without cause");
    store_gate_a: assert property (result_store |-> conv_done && analog_power_en)
        else $error("store while off");
    restart_gate_a: assert property (seq_restart |-> end_of_list && !flow_mode_select && !conv_halt)
        else $error("restart in trigger mode");
    halt_release_a: assert property (no_halt_req [*3] |-> !conv_halt)
        else $error("halt without request");
    soft_clear_a: assert property ($rose(sm_idle_force) |-> idle_cleared)
        else $error("soft reset left state");
endmodule // adcc_monitor

bind adcc_ctl0 adcc_monitor #(.IDX_W(IDX_W)) adcc_monitor_inst (.*);
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the converter control block.
// Assumes adcc_ctl0 and its monitor are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.vh"
module testbench;
    logic        clk, reset_n, read, write, waitrequest, irq, mcu_special_mode;
    logic        freeze_mode, wait_mode, trigger_req, conv_busy, conv_boundary;
    logic        conv_done, end_of_list, overrun_event, severe_error_event;
    logic        analog_power_en, conv_abort, conv_launch, result_store;
    logic        seq_restart, sm_idle_force, conv_halt, flow_mode_select;
    logic        active_command_list_select, active_result_list_select, abort_store_select;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0]  byteenable;
    logic [5:0]  command_index, result_index;
    logic [1:0]  flow_reg_access_path;
    logic [15:0] cur, w;
    logic        smod;
    int          n_errors, tests_run, n_abort, k, n;
    localparam logic [5:0] P_TRG = 6'h20, P_DONE = 6'h10, P_EOL = 6'h08, P_OVR = 6'h04, P_SEV = 6'h02;

    adcc_ctl0 #(.REC_CYC(3)) adcc_ctl0_inst (.*);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
        if (conv_abort === 1'b1)
            n_abort <= n_abort + 1;

    function automatic logic [15:0] exp_ctl(input logic [15:0] old, input logic [15:0] wd, input logic lock);
        exp_ctl = {wd[15], 1'b0, wd[13:12], lock ? old[11:8] : wd[11:8], 8'h00};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        read      <= ~wr;
        write     <= wr;
        address   <= a;
        writedata <= d;
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (waitrequest !== 1'b0 && t < 20);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0 && t >= 20)
        begin
            n_errors++;
            finish_test;
        end
    endtask

    task automatic poll(input logic [4:0] a, input int b, input logic val);
        int t;
        t = 0;
        do
        begin
            bus(1'b0, a, 32'h0);
            t++;
        end
        while (rd[b] !== val && t < 30);
        if (rd[b] !== val)
        begin
            n_errors++;
            finish_test;
        end
    endtask

    task automatic hit(input logic [5:0] p);
        @(posedge clk);
        {trigger_req, conv_done, end_of_list, overrun_event, severe_error_event, conv_boundary} <= p;
        #1;
    endtask

    // ------
    // Tests
    // ------
    initial
    begin
        reset_n = 1'b0; read = 1'b0; write = 1'b0; address = 5'h0; writedata = 32'h0;
        byteenable = 4'hf; mcu_special_mode = 1'b0; freeze_mode = 1'b0; wait_mode = 1'b0;
        conv_busy = 1'b0;
        {trigger_req, conv_done, end_of_list, overrun_event, severe_error_event, conv_boundary} = 6'h0;
        void'($urandom(32'h76327b53));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        bus(1'b0, `ADCC_OFF_CTL0, 32'h0);
        check("ctl0 reset", rd, 32'h0);
        check("access path", flow_reg_access_path, 2'h0);
        $display("test reset done");

        cur = 16'h0;
        smod = 1'b0;
        for (k = 0; k < 12; k++)
        begin
            if (k == 6)
            begin
                mcu_special_mode <= 1'b1;
                bus(1'b1, `ADCC_OFF_AUX, 32'h1);
                smod = 1'b1;
            end
            w = 16'($urandom);
            w[14] = 1'b0;
            bus(1'b1, `ADCC_OFF_CTL0, {16'h0, w});
            cur = exp_ctl(cur, w, cur[15] & ~smod);
            bus(1'b0, `ADCC_OFF_CTL0, 32'h0);
            check("ctl0", rd, {16'h0, cur});
            check("fields", {flow_reg_access_path, abort_store_select, flow_mode_select}, cur[11:8]);
            check("power", analog_power_en, cur[15]);
        end
        bus(1'b1, `ADCC_OFF_CTL0, 32'h0);
        bus(1'b1, `ADCC_OFF_AUX, 32'h0);
        mcu_special_mode <= 1'b0;
        $display("test write locks done");

        bus(1'b1, `ADCC_OFF_CTL0, 32'h8000);
        hit(P_TRG);
        check("early launch", conv_launch, 1'b0);
        hit(6'h0);
        bus(1'b0, `ADCC_OFF_IRQ_STAT, 32'h0);
        check("early flag", rd[`ADCC_IRQ_EARLY], 1'b1);
        poll(`ADCC_OFF_STATUS, `ADCC_ST_READY, 1'b1);
        n = 1 + $urandom % 5;
        for (k = 0; k < n; k++)
        begin
            hit(P_TRG | P_DONE);
            check("launch", {conv_launch, result_store}, 2'b11);
        end
        hit(6'h0);
        check("cmd index", command_index, n);
        check("res index", result_index, n);
        hit(P_EOL);
        check("restart", seq_restart, 1'b1);
        hit(P_SEV);
        check("lists", {active_command_list_select, active_result_list_select, command_index}, 8'hc0);
        hit(P_OVR | P_TRG);
        check("severe stop", conv_launch, 1'b0);
        hit(6'h0);
        bus(1'b1, `ADCC_OFF_CTL0, 32'hc000);
        bus(1'b1, `ADCC_OFF_CTL0, 32'h8000);
        poll(`ADCC_OFF_CTL0, `ADCC_CTL0_SR, 1'b0);
        bus(1'b0, `ADCC_OFF_IRQ_STAT, 32'h0);
        check("flags", rd[2:0], 3'h0);
        check("sr done", rd[`ADCC_IRQ_SR_DONE], 1'b1);
        check("idx", {active_command_list_select, active_result_list_select, command_index, result_index}, 0);
        hit(P_TRG);
        check("relaunch", conv_launch, 1'b1);
        hit(6'h0);
        $display("test sequencer done");

        conv_busy <= 1'b1;
        k = n_abort;
        bus(1'b1, `ADCC_OFF_CTL0, 32'h0);
        hit(P_DONE);
        check("drop result", result_store, 1'b0);
        repeat (2) hit(6'h0);
        check("abort pulse", n_abort - k, 1);
        bus(1'b1, `ADCC_OFF_CTL0, 32'h8000);
        bus(1'b0, `ADCC_OFF_CTL0, 32'h0);
        check("enable refused", rd[15], 1'b0);
        conv_busy <= 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b1, `ADCC_OFF_CTL0, 32'h8100);
        bus(1'b0, `ADCC_OFF_CTL0, 32'h0);
        check("enable taken", rd[15:8], 8'h81);
        poll(`ADCC_OFF_STATUS, `ADCC_ST_READY, 1'b1);
        hit(P_EOL);
        check("trigger mode", seq_restart, 1'b0);
        hit(6'h0);
        $display("test abort done");

        for (k = 0; k < 4; k++)
        begin
            w = 16'h8100;
            w[12 + k[1]] = k[0];
            bus(1'b1, `ADCC_OFF_CTL0, {16'h0, w});
            freeze_mode <= k[1];
            wait_mode <= ~k[1];
            repeat (3) @(posedge clk);
            #1 check("halt", conv_halt, k[0]);
            hit(P_TRG);
            check("halt launch", conv_launch, !k[0]);
            hit(6'h0);
            freeze_mode <= 1'b0;
            wait_mode <= 1'b0;
            repeat (3) @(posedge clk);
            #1 check("unhalt", conv_halt, 1'b0);
        end
        $display("test halt done");

        bus(1'b1, `ADCC_OFF_IRQ_EN, 32'h1f);
        #1 check("irq set", irq, 1'b1);
        bus(1'b1, `ADCC_OFF_IRQ_CLR, 32'h1f);
        #1 check("irq clr", irq, 1'b0);
        bus(1'b1, `ADCC_OFF_IRQ_EN, 32'h0);
        hit(P_OVR);
        hit(6'h0);
        check("irq masked", irq, 1'b0);
        bus(1'b0, `ADCC_OFF_IRQ_STAT, 32'h0);
        check("overrun", rd[`ADCC_IRQ_OVERRUN], 1'b1);
        bus(1'b0, 5'h18, 32'h0);
        check("unmapped", rd, 32'h0);
        $display("test irq done");
        finish_test;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test;
    end
endmodule // testbench
`default_nettype wire
